/* File: logic/tlsrq_consts.svh */
`ifndef TLSRQ_CONSTS_SVH
`define TLSRQ_CONSTS_SVH

`define TLSRQ_OFS_FATAL_TEMP 8'h26
`define TLSRQ_OFS_WARN_TEMP 8'h27
`define TLSRQ_OFS_SRQ_MASK 8'h28

`define TLSRQ_MASK_VALID 16'h1fff
`define TLSRQ_MASK_RESET 16'h1fbf
`define TLSRQ_FATAL_TEMP_RESET 16'h01f4
`define TLSRQ_WARN_TEMP_RESET 16'h00c8
`define TLSRQ_TEMP_LIMIT_MAX 16'h1388

`define TLSRQ_LOCK_GATED 16'h0707
`define TLSRQ_THERMAL_BITS 16'h0202

`define TLSRQ_ST_OK 2'h0
`define TLSRQ_ST_XE 2'h1
`define TLSRQ_ST_CE 2'h2

`define TLSRQ_ERR_OK 4'h0
`define TLSRQ_ERR_RNW 4'h1
`define TLSRQ_ERR_RVE 4'h2
`define TLSRQ_ERR_CIP 4'h3
`define TLSRQ_ERR_CII 4'h4

`endif

/* File: logic/tlsrq_pkg.sv */
`default_nettype none
package tlsrq_pkg;

  typedef struct packed {
    logic write;
    logic [7:0] addr;
    logic [15:0] data;
  } tlsrq_cmd_t;

  typedef struct packed {
    logic [1:0] status;
    logic [15:0] data;
  } tlsrq_rsp_t;

endpackage : tlsrq_pkg
`default_nettype wire

/* File: logic/tlsrq_regs.sv */
// Contract
// R1: Fatal temperature limit register, read/write, retained.
// R2: Warning temperature limit register, read/write, retained.
// R3: Out-of-range limit write gives XE, VALUE_RANGE_ERROR_CODE.
// R4: Good write: OK, echo, effective now.
// R5: Failed access: XE, zero data, error set.
// R6: Defaults fixed; saved values survive restore.
// R7: Host keeps warning limit not above fatal.
// R8: Mask bit one lets status raise request.
// R9: Mask bits align with status bit positions.
// R10: Mask field layout; bits 13-15 zero.
// R11: Mask default is a suggested pattern.
// R12: Unlocked laser blocks frequency, thermal, power.
// R13: Case temperature still requests via thermal bits.
// R14: Later execution errors set execution latch.
// R15: Communication errors answered in the response.
// R16: Request drops on mask or latch clear.
// R17: Mask write immediate, never range error.
// R18: Request low when masked latches nonzero.
`timescale 1ns/1ps
`default_nettype none
`include "tlsrq_consts.svh"

module tlsrq_regs
  import tlsrq_pkg::*;
#(
  parameter logic [15:0] FATAL_TEMP_DEFAULT = `TLSRQ_FATAL_TEMP_RESET,
  parameter logic [15:0] WARN_TEMP_DEFAULT = `TLSRQ_WARN_TEMP_RESET,
  parameter logic [15:0] MASK_DEFAULT = `TLSRQ_MASK_RESET,
  parameter logic [15:0] TEMP_LIMIT_MAX = `TLSRQ_TEMP_LIMIT_MAX
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmdValid,
  input wire tlsrq_cmd_t cmd,
  input wire logic cmdCommErr,
  input wire logic cmdBusy,
  output logic rspValid,
  output tlsrq_rsp_t rsp,
  output logic [3:0] opErrCode,
  input wire logic [15:0] statusLatch,
  input wire logic laserLocked,
  input wire logic caseTempAlarm,
  input wire logic pendingExecFail,
  output logic execErrLatchSet,
  input wire logic nvSave,
  input wire logic nvLoad,
  output logic [15:0] fatalTempLimit,
  output logic [15:0] warnTempLimit,
  output logic [15:0] serviceRequestMask,
  output logic serviceRequestLine_n
);

  function automatic logic tempInRange(input logic [15:0] value);
    tempInRange = (value <= TEMP_LIMIT_MAX);
  endfunction : tempInRange

  logic [15:0] fatalTemp_q;
  logic [15:0] warnTemp_q;
  logic [15:0] srqMask_q;
  logic [15:0] fatalTempNv_q;
  logic [15:0] warnTempNv_q;
  logic [15:0] srqMaskNv_q;
  logic rspValid_q;
  tlsrq_rsp_t rsp_q;
  logic [3:0] opErr_q;
  logic srqN_q;
  logic execSet_q;

  logic hitFatal;
  logic hitWarn;
  logic hitMask;
  logic mapped;
  logic wrOk;
  logic rdOk;
  logic rangeBad;
  logic [15:0] readData;
  logic [15:0] qualMask;
  logic [15:0] srqCauses;

  assign hitFatal = (cmd.addr == `TLSRQ_OFS_FATAL_TEMP);
  assign hitWarn = (cmd.addr == `TLSRQ_OFS_WARN_TEMP);
  assign hitMask = (cmd.addr == `TLSRQ_OFS_SRQ_MASK);
  assign mapped = hitFatal | hitWarn | hitMask;

  // Mask writes are exempt from range checks
  assign rangeBad = cmd.write & (hitFatal | hitWarn) & ~tempInRange(cmd.data); // [R3] [R17]
  assign wrOk = cmdValid & cmd.write & ~cmdCommErr & ~cmdBusy & mapped & ~rangeBad;
  assign rdOk = cmdValid & ~cmd.write & ~cmdCommErr & ~cmdBusy & mapped;

  always_comb begin
    readData = 16'h0000;
    if (hitFatal) begin
      readData = fatalTemp_q;
    end else if (hitWarn) begin
      readData = warnTemp_q;
    end else if (hitMask) begin
      readData = srqMask_q;
    end
  end

  // Limits live in fatalTemp_q/warnTemp_q; warning <= fatal is the host's job [R7]
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fatalTemp_q <= FATAL_TEMP_DEFAULT;
    end else if (nvLoad) begin
      fatalTemp_q <= fatalTempNv_q; // [R6]
    end else if (wrOk && hitFatal) begin
      fatalTemp_q <= cmd.data; // [R1] [R4]
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      warnTemp_q <= WARN_TEMP_DEFAULT;
    end else if (nvLoad) begin
      warnTemp_q <= warnTempNv_q; // [R6]
    end else if (wrOk && hitWarn) begin
      warnTemp_q <= cmd.data; // [R2] [R4]
    end
  end

  // Reserved mask bits can never be stored
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      srqMask_q <= MASK_DEFAULT & `TLSRQ_MASK_VALID; // [R11]
    end else if (nvLoad) begin
      srqMask_q <= srqMaskNv_q; // [R6]
    end else if (wrOk && hitMask) begin
      srqMask_q <= cmd.data & `TLSRQ_MASK_VALID; // [R10] [R17]
    end
  end

  // Retained image, stands in for the non-volatile store
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fatalTempNv_q <= FATAL_TEMP_DEFAULT;
      warnTempNv_q <= WARN_TEMP_DEFAULT;
      srqMaskNv_q <= MASK_DEFAULT & `TLSRQ_MASK_VALID;
    end else if (nvSave) begin
      fatalTempNv_q <= fatalTemp_q; // [R6]
      warnTempNv_q <= warnTemp_q;
      srqMaskNv_q <= srqMask_q;
    end
  end

  // Response one cycle after the command
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rspValid_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      rspValid_q <= cmdValid;
      if (!cmdValid) begin
        rsp_q <= rsp_q;
      end else if (cmdCommErr) begin
        rsp_q <= '{status: `TLSRQ_ST_CE, data: 16'h0000}; // [R15]
      end else if (wrOk) begin
        rsp_q <= '{status: `TLSRQ_ST_OK, data: cmd.data}; // [R4]
      end else if (rdOk) begin
        rsp_q <= '{status: `TLSRQ_ST_OK, data: readData}; // [R4]
      end else begin
        rsp_q <= '{status: `TLSRQ_ST_XE, data: 16'h0000}; // [R5]
      end
    end
  end

  // Error field holds the outcome of the last command without a communication error
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      opErr_q <= `TLSRQ_ERR_OK;
    end else if (cmdValid && !cmdCommErr) begin
      if (cmdBusy) begin
        opErr_q <= `TLSRQ_ERR_CIP; // [R5]
      end else if (!mapped) begin
        opErr_q <= `TLSRQ_ERR_CII; // [R5]
      end else if (rangeBad) begin
        opErr_q <= `TLSRQ_ERR_RVE; // [R3]
      end else begin
        opErr_q <= `TLSRQ_ERR_OK;
      end
    end
  end

  // Deferred failures cannot answer a packet, so raise the latch
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      execSet_q <= 1'b0;
    end else begin
      execSet_q <= pendingExecFail; // [R14]
    end
  end

  // Lock gating; case temperature keeps thermal bits live
  always_comb begin
    qualMask = srqMask_q; // [R8] [R9]
    if (!laserLocked) begin
      qualMask = srqMask_q & ~`TLSRQ_LOCK_GATED; // [R12]
      if (caseTempAlarm) begin
        qualMask = qualMask | (srqMask_q & `TLSRQ_THERMAL_BITS); // [R13]
      end
    end
  end

  assign srqCauses = statusLatch & qualMask; // [R9]

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      srqN_q <= 1'b1;
    end else begin
      srqN_q <= ~(|srqCauses); // [R18] [R16]
    end
  end

  assign rspValid = rspValid_q;
  assign rsp = rsp_q;
  assign opErrCode = opErr_q;
  assign execErrLatchSet = execSet_q;
  assign fatalTempLimit = fatalTemp_q;
  assign warnTempLimit = warnTemp_q;
  assign serviceRequestMask = srqMask_q;
  assign serviceRequestLine_n = srqN_q;

  chk_range_reject: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
    cmdValid && cmd.write && hitFatal && !cmdCommErr && !cmdBusy && cmd.data > TEMP_LIMIT_MAX
    |=> rsp.status == `TLSRQ_ST_XE && opErrCode == `TLSRQ_ERR_RVE && fatalTempLimit == $past(fatalTempLimit))
    else $error("Out-of-range limit accepted");

  chk_write_echo: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
    wrOk |=> rspValid && rsp.status == `TLSRQ_ST_OK && rsp.data == $past(cmd.data))
    else $error("Write not echoed");

  chk_fatal_update: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
    wrOk && hitFatal && !nvLoad |=> fatalTempLimit == $past(cmd.data))
    else $error("Fatal limit not updated");

  chk_warn_update: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
    wrOk && hitWarn && !nvLoad |=> warnTempLimit == $past(cmd.data))
    else $error("Warning limit not updated");

  chk_fail_zero: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
    rspValid && rsp.status != `TLSRQ_ST_OK |-> rsp.data == 16'h0000)
    else $error("Failed access returned data");

  chk_nv_restore: assert property (@(posedge clk) disable iff (sys_rst) // [R6]
    nvSave ##1 (!nvSave && !cmdValid)[*1] ##0 nvLoad |=> serviceRequestMask == $past(serviceRequestMask, 2))
    else $error("Saved mask not restored");

  chk_mask_reserved: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
    serviceRequestMask[15:13] == 3'h0)
    else $error("Reserved mask bits set");

  chk_mask_no_rve: assert property (@(posedge clk) disable iff (sys_rst) // [R17]
    cmdValid && cmd.write && hitMask && !cmdCommErr && !cmdBusy && !nvLoad
    |=> opErrCode != `TLSRQ_ERR_RVE && serviceRequestMask == ($past(cmd.data) & 16'h1fff))
    else $error("Mask write not immediate");

  chk_srq_cause: assert property (@(posedge clk) disable iff (sys_rst) // [R18]
    ##1 serviceRequestLine_n == !(|$past(srqCauses)))
    else $error("Request line mismatch");

  chk_unlock_block: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
    !laserLocked && !caseTempAlarm && (statusLatch & 16'hf8f8) == 16'h0000 |=> serviceRequestLine_n)
    else $error("Request while unlocked");

  chk_case_temp: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
    caseTempAlarm && statusLatch[1] && serviceRequestMask[1] |=> !serviceRequestLine_n)
    else $error("Case temperature request missing");

  chk_pend_latch: assert property (@(posedge clk) disable iff (sys_rst) // [R14]
    pendingExecFail |=> execErrLatchSet)
    else $error("Pending failure not latched");

  chk_comm_err: assert property (@(posedge clk) disable iff (sys_rst) // [R15]
    cmdValid && cmdCommErr |=> rspValid && rsp.status == `TLSRQ_ST_CE)
    else $error("Communication error not answered");

endmodule : tlsrq_regs
`default_nettype wire

/* File: sim/tlsrq_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tlsrq_host_model
  import tlsrq_pkg::*;
(
  input wire logic clk,
  output logic cmdValid,
  output tlsrq_cmd_t cmd,
  output logic cmdCommErr,
  output logic cmdBusy,
  input wire logic rspValid,
  input wire tlsrq_rsp_t rsp
);
  initial begin
    cmdValid = 1'b0;
    cmd = '0;
    cmdCommErr = 1'b0;
    cmdBusy = 1'b0;
  end
  // One word per packet; flags qualify only the packet cycle
  task automatic access(input logic ce, input logic bz, input logic wr, input logic [7:0] a,
                        input logic [15:0] d, output tlsrq_rsp_t r, output logic seen);
    r = '0;
    seen = 1'b0;
    @(posedge clk);
    cmdValid <= 1'b1;
    cmd <= '{write: wr, addr: a, data: d};
    cmdCommErr <= ce;
    cmdBusy <= bz;
    @(posedge clk);
    cmdValid <= 1'b0;
    // Released lines carry junk, not the last word
    cmd <= ~cmd;
    cmdCommErr <= 1'b0;
    cmdBusy <= 1'b0;
    for (int k = 0; k < 3 && !seen; k++) begin
      #1;
      if (rspValid === 1'b1) begin
        seen = 1'b1;
        r = rsp;
      end else begin
        @(posedge clk);
      end
    end
  endtask : access
endmodule : tlsrq_host_model
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tlsrq_consts.svh"
module tb
  import tlsrq_pkg::*;
;
  logic clk, sys_rst, cmdValid, cmdCommErr, cmdBusy, rspValid, laserLocked, caseTempAlarm;
  logic pendingExecFail, execErrLatchSet, nvSave, nvLoad, serviceRequestLine_n;
  tlsrq_cmd_t cmd;
  tlsrq_rsp_t rsp;
  logic [3:0] opErrCode;
  logic [15:0] statusLatch, fatalTempLimit, warnTempLimit, serviceRequestMask;
  int errors = 0;
  int nTests = 0;
  tlsrq_host_model u_tlsrq_host_model (.clk(clk), .cmdValid(cmdValid), .cmd(cmd), .cmdCommErr(cmdCommErr),
    .cmdBusy(cmdBusy), .rspValid(rspValid), .rsp(rsp));
  tlsrq_regs u_tlsrq_regs (.clk(clk), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmd(cmd),
    .cmdCommErr(cmdCommErr), .cmdBusy(cmdBusy), .rspValid(rspValid), .rsp(rsp), .opErrCode(opErrCode),
    .statusLatch(statusLatch), .laserLocked(laserLocked), .caseTempAlarm(caseTempAlarm),
    .pendingExecFail(pendingExecFail), .execErrLatchSet(execErrLatchSet), .nvSave(nvSave), .nvLoad(nvLoad),
    .fatalTempLimit(fatalTempLimit), .warnTempLimit(warnTempLimit), .serviceRequestMask(serviceRequestMask),
    .serviceRequestLine_n(serviceRequestLine_n));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    nTests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic ce, input logic bz, input logic wr, input logic [7:0] a, input logic [15:0] d,
                     input logic [1:0] st, input logic [15:0] ed, input logic [3:0] ec);
    tlsrq_rsp_t r;
    logic seen;
    u_tlsrq_host_model.access(ce, bz, wr, a, d, r, seen);
    chk({17'h0, seen}, 18'h1);
    chk({r.status, r.data}, {st, ed});
    chk({14'h0, opErrCode}, {14'h0, ec});
  endtask : acc
  task automatic srq(input logic [15:0] lat, input logic lk, input logic ct, input logic expN);
    @(posedge clk);
    statusLatch <= lat;
    laserLocked <= lk;
    caseTempAlarm <= ct;
    repeat (2) @(posedge clk);
    #1;
    chk({17'h0, serviceRequestLine_n}, {17'h0, expN});
  endtask : srq
  task automatic nv(input logic sv);
    @(posedge clk);
    nvSave <= sv;
    nvLoad <= ~sv;
    @(posedge clk);
    nvSave <= 1'b0;
    nvLoad <= 1'b0;
  endtask : nv
  task automatic test_regs;
    tlsrq_rsp_t r;
    logic seen;
    acc(0, 0, 0, 8'h26, 16'h0, `TLSRQ_ST_OK, `TLSRQ_FATAL_TEMP_RESET, `TLSRQ_ERR_OK);
    acc(0, 0, 0, 8'h27, 16'h0, `TLSRQ_ST_OK, `TLSRQ_WARN_TEMP_RESET, `TLSRQ_ERR_OK);
    acc(0, 0, 0, 8'h28, 16'h0, `TLSRQ_ST_OK, `TLSRQ_MASK_RESET, `TLSRQ_ERR_OK);
    acc(0, 0, 1, 8'h26, 16'h1388, `TLSRQ_ST_OK, 16'h1388, `TLSRQ_ERR_OK);
    chk({2'h0, fatalTempLimit}, 18'h1388);
    acc(0, 0, 1, 8'h27, 16'h1389, `TLSRQ_ST_XE, 16'h0, `TLSRQ_ERR_RVE);
    acc(0, 0, 1, 8'h26, 16'h1389, `TLSRQ_ST_XE, 16'h0, `TLSRQ_ERR_RVE);
    chk({2'h0, warnTempLimit}, {2'h0, `TLSRQ_WARN_TEMP_RESET});
    // Warning limit kept at or below the fatal one
    acc(0, 0, 1, 8'h27, 16'h1388, `TLSRQ_ST_OK, 16'h1388, `TLSRQ_ERR_OK);
    u_tlsrq_host_model.access(0, 0, 1, 8'h28, 16'hffff, r, seen);
    chk({seen, 15'h0, r.status}, {1'b1, 15'h0, `TLSRQ_ST_OK});
    acc(0, 0, 0, 8'h28, 16'h0, `TLSRQ_ST_OK, 16'h1fff, `TLSRQ_ERR_OK);
    acc(0, 1, 1, 8'h26, 16'h0005, `TLSRQ_ST_XE, 16'h0, `TLSRQ_ERR_CIP);
    acc(0, 0, 1, 8'h29, 16'h0005, `TLSRQ_ST_XE, 16'h0, `TLSRQ_ERR_CII);
    acc(1, 0, 0, 8'h26, 16'h0, `TLSRQ_ST_CE, 16'h0, `TLSRQ_ERR_CII);
    chk({2'h0, fatalTempLimit}, 18'h1388);
  endtask : test_regs
  task automatic test_srq;
    logic [15:0] gated;
    gated = `TLSRQ_LOCK_GATED;
    for (int i = 0; i < 13; i++) begin
      srq(16'h1 << i, 1'b1, 1'b0, 1'b0);
      srq(16'h1 << i, 1'b0, 1'b0, gated[i]);
    end
    srq(16'he000, 1'b1, 1'b0, 1'b1);
    srq(16'h0002, 1'b0, 1'b1, 1'b0);
    srq(16'h0200, 1'b0, 1'b1, 1'b0);
    srq(16'h0005, 1'b0, 1'b1, 1'b1);
    srq(16'h0008, 1'b1, 1'b0, 1'b0);
    acc(0, 0, 1, 8'h28, 16'h1ff7, `TLSRQ_ST_OK, 16'h1ff7, `TLSRQ_ERR_OK);
    srq(16'h0008, 1'b1, 1'b0, 1'b1);
    srq(16'h0010, 1'b1, 1'b0, 1'b0);
    srq(16'h0000, 1'b1, 1'b0, 1'b1);
  endtask : test_srq
  task automatic test_misc;
    @(posedge clk);
    pendingExecFail <= 1'b1;
    @(posedge clk);
    pendingExecFail <= 1'b0;
    #1;
    chk({17'h0, execErrLatchSet}, 18'h1);
    @(posedge clk);
    #1;
    chk({17'h0, execErrLatchSet}, 18'h0);
    acc(0, 0, 1, 8'h27, 16'h0100, `TLSRQ_ST_OK, 16'h0100, `TLSRQ_ERR_OK);
    nv(1'b1);
    acc(0, 0, 1, 8'h27, 16'h0200, `TLSRQ_ST_OK, 16'h0200, `TLSRQ_ERR_OK);
    nv(1'b0);
    acc(0, 0, 0, 8'h27, 16'h0, `TLSRQ_ST_OK, 16'h0100, `TLSRQ_ERR_OK);
    // Save then restore back to back
    @(posedge clk);
    nvSave <= 1'b1;
    @(posedge clk);
    nvSave <= 1'b0;
    nvLoad <= 1'b1;
    @(posedge clk);
    nvLoad <= 1'b0;
    #1;
    chk({2'h0, serviceRequestMask}, 18'h1ff7);
  endtask : test_misc
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    sys_rst = 1'b1;
    statusLatch = 16'h0;
    laserLocked = 1'b1;
    caseTempAlarm = 1'b0;
    pendingExecFail = 1'b0;
    nvSave = 1'b0;
    nvLoad = 1'b0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk({1'b0, serviceRequestLine_n, serviceRequestMask}, {2'h1, `TLSRQ_MASK_RESET});
    test_regs();
    test_srq();
    test_misc();
    report_and_stop();
  end
  // Whole run needs under two hundred cycles
  initial begin
    #(50 * 3000);
    errors++;
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
